// [hdl/csh_device.sv]
`timescale 1ns/100ps
module csh_device (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  csh_if.dev bus,
  output logic [csh_pkg::NCH-1:0] chan_run_o,
  output logic [csh_pkg::NCH-1:0][csh_pkg::FW-1:0] nco_freq_o
);
  localparam int NCH = csh_pkg::NCH;

  // ****************************************
  // Sync pin synchroniser and edge detect
  // ****************************************
  logic [csh_pkg::NPIN-1:0] pin_s1_q;
  logic [csh_pkg::NPIN-1:0] pin_s2_q;
  logic [csh_pkg::NPIN-1:0] pin_prev_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_prev_q <= '0;
    end
    else
    begin
      pin_s1_q <= bus.sync_pin;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  wire [csh_pkg::NPIN-1:0] pin_rise = pin_s2_q & ~pin_prev_q;

  // ****************************************
  // Decode
  // ****************************************
  wire wr_sleep = bus.wr_en && (bus.addr == csh_pkg::ADDR_SLEEP);
  wire wr_pin_ctl = bus.wr_en && (bus.addr == csh_pkg::ADDR_PIN_CTL);
  wire wr_soft_ctl = bus.wr_en && (bus.addr == csh_pkg::ADDR_SOFT_CTL);
  wire wr_pin_sel = bus.wr_en && (bus.addr == csh_pkg::ADDR_PIN_SEL);
  wire wr_start_hold = bus.wr_en && (bus.addr == csh_pkg::ADDR_START_HOLD);
  wire wr_freq_hold = bus.wr_en && (bus.addr == csh_pkg::ADDR_FREQ_HOLD);
  wire wr_freq_lo = bus.wr_en && (bus.addr == csh_pkg::ADDR_FREQ_LO);
  wire wr_freq_hi = bus.wr_en && (bus.addr == csh_pkg::ADDR_FREQ_HI);

  logic [7:0] sleep_q;
  logic [7:0] pin_ctl_q;
  logic [7:0] soft_ctl_q;
  logic [7:0] pin_sel_q;
  wire [NCH-1:0] start_fire;
  wire [NCH-1:0] hop_fire;
  logic [NCH-1:0][csh_pkg::HW-1:0] start_hold_q;
  logic [NCH-1:0][csh_pkg::HW-1:0] freq_hold_q;
  logic [NCH-1:0][csh_pkg::FW-1:0] shadow_q;

  // Host write and hardware wake may meet; the wake is applied last
  wire [7:0] sleep_d = (wr_sleep ? bus.wdata[7:0] : sleep_q) & ~{4'h0, start_fire}; // R17 R8 R10 R6

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sleep_q <= csh_pkg::SLEEP_RST; // R1
      chan_run_o <= '0; // R1
      pin_ctl_q <= '0;
      soft_ctl_q <= '0;
      pin_sel_q <= '0;
    end
    else
    begin
      sleep_q <= sleep_d;
      chan_run_o <= ~sleep_d[NCH-1:0]; // R6
      if (wr_pin_ctl)
        pin_ctl_q <= bus.wdata[7:0];
      if (wr_soft_ctl)
        soft_ctl_q <= bus.wdata[7:0];
      if (wr_pin_sel)
        pin_sel_q <= bus.wdata[7:0];
    end
  end

  // ****************************************
  // Triggers and latency alignment
  // ****************************************
  localparam int NKIND_W = csh_pkg::NKIND;
  wire [NKIND_W-1:0][NCH-1:0] trig;
  logic [NCH-1:0] dly_q [NKIND_W][csh_pkg::MAXD];
  wire [NKIND_W-1:0][NCH-1:0] tap;

  genvar c, k;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_trig
      wire [csh_pkg::SELW-1:0] sel = pin_sel_q[c*csh_pkg::SELW +: csh_pkg::SELW]; // R3
      wire hit = pin_rise[sel] && pin_ctl_q[csh_pkg::PIN_EN_LSB + int'(sel)]; // R3
      wire armed = soft_ctl_q[csh_pkg::SYNC_LSB + c];
      wire soft_sel = wr_soft_ctl && bus.wdata[csh_pkg::SYNC_LSB + c];
      assign trig[csh_pkg::K_START_SOFT][c] = soft_sel && bus.wdata[csh_pkg::SOFT_START_BIT]; // R2 R8
      assign trig[csh_pkg::K_HOP_SOFT][c] = soft_sel && bus.wdata[csh_pkg::SOFT_HOP_BIT]; // R2 R13
      assign trig[csh_pkg::K_START_PIN][c] = hit && armed && pin_ctl_q[csh_pkg::PIN_START_BIT]; // R2 R10
      assign trig[csh_pkg::K_HOP_PIN][c] = hit && armed && pin_ctl_q[csh_pkg::PIN_HOP_BIT]; // R15
    end

    for (k = 0; k < NKIND_W; k++)
    begin : g_dly
      always_ff @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          for (int i = 0; i < csh_pkg::MAXD; i++)
            dly_q[k][i] <= '0;
        end
        else
        begin
          dly_q[k][0] <= trig[k];
          for (int i = 1; i < csh_pkg::MAXD; i++)
            dly_q[k][i] <= dly_q[k][i-1];
        end
      end
      assign tap[k] = dly_q[k][csh_pkg::DLY_TAB[k] - 1]; // R9 R11 R14 R16
    end

    // ****************************************
    // Per-channel hold-off counters and shadows
    // ****************************************
    for (c = 0; c < NCH; c++)
    begin : g_chan
      logic [csh_pkg::HW-1:0] sctr_q;
      logic [csh_pkg::HW-1:0] hctr_q;
      logic sbusy_q;
      logic hbusy_q;
      wire sel_me = (int'(bus.chan_sel) == c);
      wire s_load = tap[csh_pkg::K_START_SOFT][c] | tap[csh_pkg::K_START_PIN][c];
      wire h_load = tap[csh_pkg::K_HOP_SOFT][c] | tap[csh_pkg::K_HOP_PIN][c];
      wire [csh_pkg::FW-1:0] shadow_d = (wr_freq_lo && sel_me) ? {shadow_q[c][31:16], bus.wdata} :
                                        (wr_freq_hi && sel_me) ? {bus.wdata, shadow_q[c][15:0]} :
                                        shadow_q[c];
      wire imm = (wr_freq_lo || wr_freq_hi) && sel_me && (freq_hold_q[c] == csh_pkg::HOLD_ZERO); // R12
      assign start_fire[c] = sbusy_q && (sctr_q == csh_pkg::HOLD_ONE) && !s_load; // R8 R10
      assign hop_fire[c] = hbusy_q && (hctr_q == csh_pkg::HOLD_ONE) && !h_load; // R13

      always_ff @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          sctr_q <= '0;
          hctr_q <= '0;
          sbusy_q <= 1'b0;
          hbusy_q <= 1'b0;
          start_hold_q[c] <= '0;
          freq_hold_q[c] <= '0;
          shadow_q[c] <= '0;
          nco_freq_o[c] <= '0;
        end
        else
        begin
          if (wr_start_hold && sel_me)
            start_hold_q[c] <= bus.wdata;
          if (wr_freq_hold && sel_me)
            freq_hold_q[c] <= bus.wdata;
          shadow_q[c] <= shadow_d; // R4
          if (s_load)
          begin
            sctr_q <= start_hold_q[c];
            sbusy_q <= (start_hold_q[c] != csh_pkg::HOLD_ZERO);
          end
          else if (start_fire[c])
            sbusy_q <= 1'b0; // R18
          else if (sbusy_q)
            sctr_q <= sctr_q - csh_pkg::HOLD_ONE; // R8
          if (h_load)
          begin
            hctr_q <= freq_hold_q[c];
            hbusy_q <= (freq_hold_q[c] != csh_pkg::HOLD_ZERO);
          end
          else if (hop_fire[c])
            hbusy_q <= 1'b0; // R18
          else if (hbusy_q)
            hctr_q <= hctr_q - csh_pkg::HOLD_ONE; // R13
          if (hop_fire[c])
            nco_freq_o[c] <= shadow_q[c]; // R4 R13
          else if (imm)
            nco_freq_o[c] <= shadow_d; // R12
        end
      end
    end
  endgenerate

  // ****************************************
  // Readback and ready
  // ****************************************
  wire [csh_pkg::DW-1:0] rd_mux =
    (bus.addr == csh_pkg::ADDR_SLEEP) ? {8'h00, sleep_q} :
    (bus.addr == csh_pkg::ADDR_PIN_CTL) ? {8'h00, pin_ctl_q} :
    (bus.addr == csh_pkg::ADDR_SOFT_CTL) ? {8'h00, soft_ctl_q} :
    (bus.addr == csh_pkg::ADDR_PIN_SEL) ? {8'h00, pin_sel_q} :
    (bus.addr == csh_pkg::ADDR_START_HOLD) ? start_hold_q[bus.chan_sel] :
    (bus.addr == csh_pkg::ADDR_FREQ_HOLD) ? freq_hold_q[bus.chan_sel] :
    (bus.addr == csh_pkg::ADDR_FREQ_LO) ? shadow_q[bus.chan_sel][15:0] :
    (bus.addr == csh_pkg::ADDR_FREQ_HI) ? shadow_q[bus.chan_sel][31:16] :
    16'h0000;

  logic ready_q;
  logic rd_valid_q;
  logic [csh_pkg::DW-1:0] rdata_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ready_q <= 1'b1;
      rd_valid_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      // Low for one cycle per access; its rise times soft syncs
      ready_q <= !(bus.wr_en || bus.rd_en); // R9 R14
      rd_valid_q <= bus.rd_en;
      if (bus.rd_en)
        rdata_q <= rd_mux;
    end
  end
  assign bus.ready = ready_q;
  assign bus.rd_valid = rd_valid_q;
  assign bus.rdata = rdata_q;
endmodule // csh_device

// [hdl/csh_pkg.sv]
// Operation
// R1 - Hard reset puts every channel asleep
// R2 - Countdown triggered by soft write or pin
// R3 - Each channel picks any of four pins
// R4 - Shadow plus countdown; change lands at end
// R5 - Host sleeps channel before loading its setup
// R6 - Unsynced start: hold-off one, clear sleep
// R7 - Host programs hold-off above 1, below 65535
// R8 - Soft start counts down, wakes channels at one
// R9 - Soft start runs hold-off plus 6 after ready
// R10 - Pin start counts down, wakes channels at one
// R11 - Pin start runs hold-off plus 3 after pin
// R12 - Zero frequency hold-off loads frequency at once
// R13 - Hop countdown loads pending frequency at one
// R14 - Soft hop applies hold-off plus 7 after ready
// R15 - Pin hop starts countdown on sampled pin
// R16 - Pin hop applies hold-off plus 5 after pin
// R17 - Host may force any channel asleep anytime; a countdown wake in the same cycle overrides the sleep write
// R18 - Counter stops after acting until next trigger
package csh_pkg;
  localparam int NCH = 4;
  localparam int NPIN = 4;
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int HW = 16;
  localparam int FW = 32;
  localparam int SELW = 2;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [AW-1:0] ADDR_SLEEP = 8'h03;
  localparam logic [AW-1:0] ADDR_PIN_CTL = 8'h04;
  localparam logic [AW-1:0] ADDR_SOFT_CTL = 8'h05;
  localparam logic [AW-1:0] ADDR_PIN_SEL = 8'h07;
  localparam logic [AW-1:0] ADDR_START_HOLD = 8'h83;
  localparam logic [AW-1:0] ADDR_FREQ_HOLD = 8'h84;
  localparam logic [AW-1:0] ADDR_FREQ_LO = 8'h85;
  localparam logic [AW-1:0] ADDR_FREQ_HI = 8'h86;

  localparam logic [7:0] SLEEP_RST = 8'h0f;
  localparam logic [HW-1:0] HOLD_ONE = 16'h0001;
  localparam logic [HW-1:0] HOLD_ZERO = 16'h0000;

  // ****************************************
  // Fields
  // ****************************************
  localparam int PIN_HOP_BIT = 0;
  localparam int PIN_START_BIT = 1;
  localparam int PIN_EN_LSB = 4;
  localparam int SYNC_LSB = 0;
  localparam int SOFT_START_BIT = 4;
  localparam int SOFT_HOP_BIT = 5;

  // ****************************************
  // Trigger latencies in master clock cycles
  // ****************************************
  localparam int START_SOFT_LAT = 6;
  localparam int START_PIN_LAT = 3;
  localparam int HOP_SOFT_LAT = 7;
  localparam int HOP_PIN_LAT = 5;
  // Soft path is counted from ready rising, one edge after the write
  localparam int NKIND = 4;
  localparam int K_START_SOFT = 0;
  localparam int K_START_PIN = 1;
  localparam int K_HOP_SOFT = 2;
  localparam int K_HOP_PIN = 3;
  // Pin path already spends two edges in the synchroniser
  localparam int DLY_TAB [NKIND] = '{START_SOFT_LAT + 1, START_PIN_LAT - 2,
                                     HOP_SOFT_LAT + 1, HOP_PIN_LAT - 2};
  localparam int MAXD = HOP_SOFT_LAT + 1;

  typedef enum logic {HOST_IDLE, HOST_WAIT} csh_host_state_e;
endpackage

// [hdl/csh_if.sv]
`timescale 1ns/100ps
interface csh_if;
  logic wr_en;
  logic rd_en;
  logic [csh_pkg::AW-1:0] addr;
  logic [csh_pkg::SELW-1:0] chan_sel;
  logic [csh_pkg::DW-1:0] wdata;
  logic [csh_pkg::DW-1:0] rdata;
  logic rd_valid;
  logic ready;
  logic [csh_pkg::NPIN-1:0] sync_pin;

  modport dev (
    input wr_en,
    input rd_en,
    input addr,
    input chan_sel,
    input wdata,
    input sync_pin,
    output rdata,
    output rd_valid,
    output ready
  );

  modport host (
    output wr_en,
    output rd_en,
    output addr,
    output chan_sel,
    output wdata,
    output sync_pin,
    input rdata,
    input rd_valid,
    input ready
  );
endinterface

// [hdl/csh_host.sv]
`timescale 1ns/100ps
module csh_host (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  csh_if.host bus,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [csh_pkg::AW-1:0] cmd_addr_i,
  input wire logic [csh_pkg::SELW-1:0] cmd_chan_i,
  input wire logic [csh_pkg::DW-1:0] cmd_wdata_i,
  input wire logic [csh_pkg::NPIN-1:0] sync_req_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [csh_pkg::DW-1:0] rsp_data_o
);
  // ****************************************
  // One access in flight; sequencing of sleep and hold-off is the user's
  // ****************************************
  csh_pkg::csh_host_state_e state_q;
  logic wr_q;
  logic rd_q;
  logic seen_low_q;
  logic [csh_pkg::AW-1:0] addr_q;
  logic [csh_pkg::SELW-1:0] chan_q;
  logic [csh_pkg::DW-1:0] wdata_q;
  logic [csh_pkg::NPIN-1:0] sync_q;

  wire take = cmd_valid_i && cmd_ready_o;
  wire done = (state_q == csh_pkg::HOST_WAIT) && seen_low_q && bus.ready;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= csh_pkg::HOST_IDLE;
      cmd_ready_o <= 1'b1;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      seen_low_q <= 1'b0;
      addr_q <= '0;
      chan_q <= '0;
      wdata_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      sync_q <= sync_req_i; // R2
      wr_q <= take && cmd_write_i; // R5 R6 R7
      rd_q <= take && !cmd_write_i;
      rsp_valid_o <= bus.rd_valid;
      if (bus.rd_valid)
        rsp_data_o <= bus.rdata;
      case (state_q)
        csh_pkg::HOST_IDLE:
        begin
          if (take)
          begin
            addr_q <= cmd_addr_i;
            chan_q <= cmd_chan_i;
            wdata_q <= cmd_wdata_i;
            cmd_ready_o <= 1'b0;
            seen_low_q <= 1'b0;
            state_q <= csh_pkg::HOST_WAIT;
          end
        end
        csh_pkg::HOST_WAIT:
        begin
          if (!bus.ready)
            seen_low_q <= 1'b1;
          if (done)
          begin
            cmd_ready_o <= 1'b1;
            state_q <= csh_pkg::HOST_IDLE;
          end
        end
        default:
          state_q <= csh_pkg::HOST_IDLE;
      endcase
    end
  end

  assign bus.wr_en = wr_q;
  assign bus.rd_en = rd_q;
  assign bus.addr = addr_q;
  assign bus.chan_sel = chan_q;
  assign bus.wdata = wdata_q;
  assign bus.sync_pin = sync_q;
endmodule // csh_host

// [bench/csh_props.sv]
`timescale 1ns/100ps
module csh_props (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [csh_pkg::AW-1:0] addr_i,
  input wire logic [csh_pkg::DW-1:0] wdata_i,
  input wire logic [csh_pkg::DW-1:0] rdata_i,
  input wire logic rd_valid_i,
  input wire logic ready_i,
  input wire logic [csh_pkg::NCH-1:0] chan_run_i
);
  // ****************************************
  // Bus handshake and sleep control
  // ****************************************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic strobe;
  assign strobe = wr_en_i | rd_en_i;

  a_ready_drops: assert property (strobe |=> !ready_i)
    else $error("ready stayed high after a strobe");
  a_ready_recovers: assert property (strobe ##1 !strobe |=> ready_i)
    else $error("ready did not return high");
  a_read_answers: assert property (rd_en_i |=> rd_valid_i)
    else $error("read without rd_valid");
  a_valid_caused: assert property (rd_valid_i |-> $past(rd_en_i))
    else $error("rd_valid without read");
  a_rdata_holds: assert property (!rd_valid_i |-> $stable(rdata_i))
    else $error("rdata moved without rd_valid");
  a_strobe_spacing: assert property (strobe |=> (!strobe) [*3])
    else $error("strobes closer than spacing");
  a_reset_asleep: assert property ($rose(rst_b_i) |-> chan_run_i == '0)
    else $error("channel awake after reset");
  // Sleep register and run flag load on the same edge as the write
  a_sleep_forced: assert property (wr_en_i && addr_i == csh_pkg::ADDR_SLEEP |->
    ##1 (chan_run_i & $past(wdata_i[csh_pkg::NCH-1:0])) == '0)
    else $error("sleep write did not stop channel");

  c_soft_ctl: cover property (wr_en_i && addr_i == csh_pkg::ADDR_SOFT_CTL);
  c_wake: cover property ($rose(chan_run_i[0]));
  c_read: cover property (rd_valid_i);
endmodule // csh_props

// [bench/channel_start_hop_sync_tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_count++; $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module channel_start_hop_sync_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [csh_pkg::AW-1:0] cmd_addr = '0;
  logic [csh_pkg::SELW-1:0] cmd_chan = '0;
  logic [csh_pkg::DW-1:0] cmd_wdata = '0;
  logic [csh_pkg::NPIN-1:0] sync_req = '0;
  logic cmd_ready;
  logic rsp_valid;
  logic [csh_pkg::DW-1:0] rsp_data;
  logic [csh_pkg::NCH-1:0] chan_run;
  logic [csh_pkg::NCH-1:0][csh_pkg::FW-1:0] nco_freq;
  logic [csh_pkg::NCH-1:0][csh_pkg::FW-1:0] nco_d;
  logic [csh_pkg::NCH-1:0] run_d;
  logic [csh_pkg::NPIN-1:0] pin_d;
  logic rdy_d;
  logic [31:0] seed = 32'h0000_2519;
  logic [csh_pkg::DW-1:0] rd;
  int cnt = 0;
  int t_rdy;
  int t_pin;
  int t_run [csh_pkg::NCH];
  int t_nco [csh_pkg::NCH];
  int err_count = 0;
  int checks = 0;

  always #4 ref_clk_i = ~ref_clk_i;

  csh_if bus_if ();
  csh_host csh_host_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus(bus_if.host), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_chan_i(cmd_chan), .cmd_wdata_i(cmd_wdata),
    .sync_req_i(sync_req), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
  csh_device csh_device_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus(bus_if.dev),
    .chan_run_o(chan_run), .nco_freq_o(nco_freq));
  csh_props csh_props_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .wr_en_i(bus_if.wr_en),
    .rd_en_i(bus_if.rd_en), .addr_i(bus_if.addr), .wdata_i(bus_if.wdata), .rdata_i(bus_if.rdata),
    .rd_valid_i(bus_if.rd_valid), .ready_i(bus_if.ready), .chan_run_i(chan_run));

  // ****************************************
  // Edge stamps; a rise seen at edge k happened at edge k-1
  // ****************************************
  always @(posedge ref_clk_i)
  begin
    cnt <= cnt + 1;
    rdy_d <= bus_if.ready;
    run_d <= chan_run;
    nco_d <= nco_freq;
    pin_d <= bus_if.sync_pin;
    if (bus_if.ready === 1'b1 && rdy_d === 1'b0)
      t_rdy <= cnt - 1;
    if ((bus_if.sync_pin & ~pin_d) != '0)
      t_pin <= cnt;
    for (int c = 0; c < csh_pkg::NCH; c++)
    begin
      if (chan_run[c] === 1'b1 && run_d[c] === 1'b0)
        t_run[c] <= cnt - 1;
      if (nco_freq[c] !== nco_d[c])
        t_nco[c] <= cnt - 1;
    end
    if (cnt == 6000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [3:0] one_hot(input int c);
    return 4'h1 << c;
  endfunction

  task automatic op(input logic wr, input logic [7:0] a, input int ch, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_chan <= ch[1:0];
    cmd_wdata <= d;
    @(posedge ref_clk_i);
    cmd_valid <= 1'b0;
    n = 0;
    while (!wr && rsp_valid !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    rd = rsp_data;
  endtask

  task automatic pulse(input int p);
    @(posedge ref_clk_i);
    sync_req <= 4'h1 << p;
    repeat (3) @(posedge ref_clk_i);
    sync_req <= '0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Scenarios, one pass per channel with a random pin
  // ****************************************
  initial
  begin
    int h;
    int p;
    logic [31:0] f;
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    `CHK("run_rst", 4'h0, chan_run)
    op(0, csh_pkg::ADDR_SLEEP, 0, 16'h0000);
    `CHK("sleep_rst", 16'h000f, rd)
    op(0, 8'h40, 0, 16'h0000);
    `CHK("unmapped", 16'h0000, rd)
    for (int c = 0; c < csh_pkg::NCH; c++)
    begin
      p = int'(xs() & 32'h0000_0003);
      h = 2 + int'(xs() & 32'h0000_001f);
      // Corner: shortest legal hold-off on the first channel
      if (c == 0)
        h = 2;
      op(1, csh_pkg::ADDR_SLEEP, 0, 16'h000f);
      op(1, csh_pkg::ADDR_START_HOLD, c, h[15:0]);
      `CHK("forced", 4'h0, chan_run)
      op(1, csh_pkg::ADDR_SOFT_CTL, 0, 16'h0010 | (16'h0001 << c));
      repeat (h + 12) @(posedge ref_clk_i);
      `CHK("soft_start", h + csh_pkg::START_SOFT_LAT, t_run[c] - t_rdy)
      `CHK("sel_only", one_hot(c), chan_run)
      op(1, csh_pkg::ADDR_SLEEP, 0, 16'h000f);
      repeat (h + 12) @(posedge ref_clk_i);
      `CHK("stopped", 4'h0, chan_run)
      op(1, csh_pkg::ADDR_START_HOLD, c, csh_pkg::HOLD_ONE);
      op(1, csh_pkg::ADDR_SLEEP, 0, 16'h000f & ~(16'h0001 << c));
      repeat (8) @(posedge ref_clk_i);
      `CHK("no_sync", one_hot(c), chan_run)
      op(1, csh_pkg::ADDR_SLEEP, 0, 16'h000f);
      op(1, csh_pkg::ADDR_START_HOLD, c, h[15:0]);
      op(1, csh_pkg::ADDR_PIN_SEL, 0, 16'(p << (2 * c)));
      op(1, csh_pkg::ADDR_SOFT_CTL, 0, 16'h0001 << c);
      op(1, csh_pkg::ADDR_PIN_CTL, 0, 16'h0002 | (16'h0010 << p));
      pulse(p);
      repeat (h + 12) @(posedge ref_clk_i);
      `CHK("pin_start", h + csh_pkg::START_PIN_LAT, t_run[c] - t_pin)
      `CHK("pin_wake", one_hot(c), chan_run)
      // Pin triggers off, so only the soft write can start the hop
      op(1, csh_pkg::ADDR_PIN_CTL, 0, 16'h0000);
      f = xs();
      op(1, csh_pkg::ADDR_FREQ_HOLD, c, h[15:0]);
      op(1, csh_pkg::ADDR_FREQ_LO, c, f[15:0]);
      op(1, csh_pkg::ADDR_FREQ_HI, c, f[31:16]);
      op(1, csh_pkg::ADDR_SOFT_CTL, 0, 16'h0020 | (16'h0001 << c));
      repeat (h + 12) @(posedge ref_clk_i);
      `CHK("soft_hop", h + csh_pkg::HOP_SOFT_LAT, t_nco[c] - t_rdy)
      `CHK("hop_val", f, nco_freq[c])
      f = xs();
      op(1, csh_pkg::ADDR_FREQ_LO, c, f[15:0]);
      op(1, csh_pkg::ADDR_FREQ_HI, c, f[31:16]);
      op(1, csh_pkg::ADDR_PIN_CTL, 0, 16'h0001 | (16'h0010 << p));
      pulse(p);
      repeat (h + 12) @(posedge ref_clk_i);
      `CHK("pin_hop", h + csh_pkg::HOP_PIN_LAT, t_nco[c] - t_pin)
      `CHK("pin_val", f, nco_freq[c])
      op(1, csh_pkg::ADDR_PIN_CTL, 0, 16'h0000);
      op(1, csh_pkg::ADDR_FREQ_HOLD, c, csh_pkg::HOLD_ZERO);
      f = xs();
      op(1, csh_pkg::ADDR_FREQ_LO, c, f[15:0]);
      repeat (3) @(posedge ref_clk_i);
      `CHK("direct", f[15:0], nco_freq[c][15:0])
    end
    report_and_stop();
  end
endmodule // channel_start_hop_sync_tb_top
